/* rtl/ctgs_consts.svh */
// register offsets, field positions, reset values and timing counts
`ifndef CTGS_CONSTS_SVH
`define CTGS_CONSTS_SVH

`define CTGS_OFF_CMP1_CTRL    12'h000
`define CTGS_OFF_CMP2_CTRL    12'h004
`define CTGS_OFF_SHARED_CTRL  12'h008
`define CTGS_OFF_PORT_READ    12'h00C
`define CTGS_OFF_ANALOG_SEL   12'h010

`define CTGS_BIT_SYNC_EN      0
`define CTGS_BIT_GATE_SEL     1
`define CTGS_BIT_HYST2        2
`define CTGS_BIT_HYST1        3
`define CTGS_BIT_ALT_CLK      4
`define CTGS_BIT_MIRROR2      6
`define CTGS_BIT_MIRROR1      7

`define CTGS_SHARED_WMASK     8'h1F
`define CTGS_SHARED_RESET     8'h02
`define CTGS_CMPX_RESET       8'h00
`define CTGS_CMPX_WMASK       8'hB7
`define CTGS_CMPX_BIT_ON      7
`define CTGS_CMPX_BIT_OUT     6
`define CTGS_CMPX_BIT_POL     4
`define CTGS_ANALOG_RESET     8'hFF

`define CTGS_FOSC_MHZ         100
`define CTGS_INSTR_DIV        4
`define CTGS_INSTR_DIV_W      2

`endif

/* rtl/ctgs_pkg.sv */
// types shared by the comparator gate block
package ctgs_pkg;

  typedef struct packed {
    logic [11:0] addr;
    logic        write;
    logic [31:0] wdata;
  } ctgs_req_s;

  typedef struct packed {
    logic gate_sel;
    logic sync_en;
    logic alt_clk;
    logic hyst1;
    logic hyst2;
  } ctgs_cfg_s;

  typedef enum logic [2:0] {
    CTGS_PH_LOW  = 3'b001,
    CTGS_PH_HIGH = 3'b010,
    CTGS_PH_IDLE = 3'b100
  } ctgs_phase_e;

endpackage

/* rtl/ctgs_top.sv */
// comparator to gate counter routing, mirror register and timer clock select
//
// Behaviour
// - gate_source_sel low routes the synchronised comparator two result to the counter gate, high routes the gate pin.
// - with cmp2_sync_enable set the comparator two result is captured at each falling counter clock edge, else passed straight.
// - the capture uses the prescaled counter clock when a prescaler is in use.
// - the counter advances on the rising counter clock edge, opposite the falling edge capture.
// - the shared register reads both comparator results in one access with no skew.
// - reading the shared register leaves the access side mismatch latches alone; only per comparator register accesses update them.
// - timer_alt_clock_sel high picks the oscillator clock, low the instruction clock at a quarter rate.
// - each hysteresis bit drives the hysteresis enable of its own comparator.
// - the unused bit five of the shared register ignores writes and reads zero.
// - every reset loads the shared register with only gate_source_sel set.
// - a port read returns zero for every pin configured as analog.
// - one mismatch latch captures the comparator on a per comparator register access, the other on every pclk cycle.
//
// Added by the designer: the placing of the registers and register access over APB.
`timescale 1ns/1ns
`include "ctgs_consts.svh"

module ctgs_top #(
  parameter int PRESCALE_W = 3
) (
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [11:0]           paddr,
  input  wire logic [31:0]           pwdata,
  output logic      [31:0]           prdata,
  output logic                       pready,
  output logic                       pslverr,
  input  wire logic                  cmp1_result,
  input  wire logic                  cmp2_result,
  input  wire logic                  timer_gate_pin,
  input  wire logic [7:0]            port_pins,
  input  wire logic [PRESCALE_W-1:0] prescale_sel,
  input  wire logic                  counter_on,
  input  wire logic                  gate_enable,
  output logic                       counter_tick,
  output logic                       count_gate,
  output logic                       cmp1_hyst_en,
  output logic                       cmp2_hyst_en,
  output logic [1:0]                 cmp_mismatch,
  output logic [1:0]                 cmp_enable
);

  // ****************************************************************
  // bus decode
  // ****************************************************************
  ctgs_pkg::ctgs_req_s req;
  wire logic acc     = psel & penable;
  wire logic wr_en   = acc & pwrite;
  wire logic hit_c1  = (paddr == `CTGS_OFF_CMP1_CTRL);
  wire logic hit_c2  = (paddr == `CTGS_OFF_CMP2_CTRL);
  wire logic hit_sh  = (paddr == `CTGS_OFF_SHARED_CTRL);
  wire logic hit_pt  = (paddr == `CTGS_OFF_PORT_READ);
  wire logic hit_an  = (paddr == `CTGS_OFF_ANALOG_SEL);
  wire logic hit_any = hit_c1 | hit_c2 | hit_sh | hit_pt | hit_an;

  assign req     = '{addr: paddr, write: pwrite, wdata: pwdata};
  assign pready  = 1'b1;
  assign pslverr = acc & ~hit_any;

  // ****************************************************************
  // registers
  // ****************************************************************
  logic [7:0] c1_ctrl_r;
  logic [7:0] c2_ctrl_r;
  logic [4:0] shared_r;
  logic [7:0] analog_r;
  ctgs_pkg::ctgs_cfg_s cfg;

  // ****************************************************************
  // configuration fields
  // ****************************************************************
  assign cfg.sync_en  = shared_r[`CTGS_BIT_SYNC_EN];
  assign cfg.gate_sel = shared_r[`CTGS_BIT_GATE_SEL];
  assign cfg.hyst2    = shared_r[`CTGS_BIT_HYST2];
  assign cfg.hyst1    = shared_r[`CTGS_BIT_HYST1];
  assign cfg.alt_clk  = shared_r[`CTGS_BIT_ALT_CLK];

  // ****************************************************************
  // register next values
  // ****************************************************************
  wire logic       wr_c1       = wr_en & hit_c1;
  wire logic       wr_c2       = wr_en & hit_c2;
  wire logic       wr_sh       = wr_en & hit_sh;
  wire logic       wr_an       = wr_en & hit_an;
  wire logic [7:0] c1_ctrl_nxt = wr_c1 ? (req.wdata[7:0] & `CTGS_CMPX_WMASK) : c1_ctrl_r;
  wire logic [7:0] c2_ctrl_nxt = wr_c2 ? (req.wdata[7:0] & `CTGS_CMPX_WMASK) : c2_ctrl_r;
  wire logic [4:0] shared_nxt  = wr_sh ? req.wdata[4:0] : shared_r;
  wire logic [7:0] analog_nxt  = wr_an ? req.wdata[7:0] : analog_r;

  // ****************************************************************
  // comparator control registers
  // ****************************************************************
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      c1_ctrl_r <= `CTGS_CMPX_RESET;
    else
      c1_ctrl_r <= c1_ctrl_nxt;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      c2_ctrl_r <= `CTGS_CMPX_RESET;
    else
      c2_ctrl_r <= c2_ctrl_nxt;
  end

  // ****************************************************************
  // shared control and analog select registers
  // ****************************************************************
  // shared reset pattern
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      shared_r <= 5'(`CTGS_SHARED_RESET);
    else
      shared_r <= shared_nxt;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      analog_r <= `CTGS_ANALOG_RESET;
    else
      analog_r <= analog_nxt;
  end

  // ****************************************************************
  // comparator results after polarity
  // ****************************************************************
  wire logic c1_out = cmp1_result ^ c1_ctrl_r[`CTGS_CMPX_BIT_POL];
  wire logic c2_out = cmp2_result ^ c2_ctrl_r[`CTGS_CMPX_BIT_POL];

  // ****************************************************************
  // comparator enables and hysteresis
  // ****************************************************************
  assign cmp_enable = {c2_ctrl_r[`CTGS_CMPX_BIT_ON], c1_ctrl_r[`CTGS_CMPX_BIT_ON]};

  assign cmp1_hyst_en = cfg.hyst1;
  assign cmp2_hyst_en = cfg.hyst2;

  // ****************************************************************
  // timer clock: select, prescale, edges
  // ****************************************************************
  logic [`CTGS_INSTR_DIV_W-1:0] div_r;
  localparam int PRE_CNT_W = (1 << PRESCALE_W) - 1;
  logic [PRE_CNT_W-1:0]         pre_r;
  ctgs_pkg::ctgs_phase_e        ph_r;
  ctgs_pkg::ctgs_phase_e        ph_nxt;

  wire logic                         src_en   = cfg.alt_clk | (div_r == '0);
  // terminal count: all ones below the selected exponent
  wire logic [PRE_CNT_W-1:0]         pre_mask = ~({PRE_CNT_W{1'b1}} << prescale_sel);
  wire logic                         pre_hit  = (pre_r == pre_mask);
  wire logic                         half_en  = src_en & pre_hit;
  wire logic [`CTGS_INSTR_DIV_W-1:0] div_nxt  = div_r + `CTGS_INSTR_DIV_W'(1);
  wire logic [PRE_CNT_W-1:0]         pre_nxt  = !src_en ? pre_r : (pre_hit ? '0 : pre_r + PRE_CNT_W'(1));

  // ****************************************************************
  // instruction rate divider
  // ****************************************************************
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      div_r <= '0;
    else
      div_r <= div_nxt;
  end

  // ****************************************************************
  // counter prescaler
  // ****************************************************************
  // divide before the edges
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pre_r <= '0;
    else
      pre_r <= pre_nxt;
  end

  // ****************************************************************
  // prescaled clock phase
  // ****************************************************************
  // prescaled timer clock as a two phase sequence
  always_comb
  begin
    ph_nxt = ph_r;
    case (ph_r)
      ctgs_pkg::CTGS_PH_IDLE: ph_nxt = ctgs_pkg::CTGS_PH_LOW;
      ctgs_pkg::CTGS_PH_LOW:  if (half_en) ph_nxt = ctgs_pkg::CTGS_PH_HIGH;
      ctgs_pkg::CTGS_PH_HIGH: if (half_en) ph_nxt = ctgs_pkg::CTGS_PH_LOW;
      default:                ph_nxt = ctgs_pkg::CTGS_PH_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      ph_r <= ctgs_pkg::CTGS_PH_IDLE;
    else
      ph_r <= ph_nxt;
  end

  // ****************************************************************
  // clock edges
  // ****************************************************************
  // edges of the prescaled clock
  wire logic rise_en = (ph_r == ctgs_pkg::CTGS_PH_LOW) & half_en;
  wire logic fall_en = (ph_r == ctgs_pkg::CTGS_PH_HIGH) & half_en;

  // ****************************************************************
  // comparator two synchroniser and gate
  // ****************************************************************
  logic sync_c2_r;
  logic tick_r;

  wire logic sync_c2_nxt = fall_en ? c2_out : sync_c2_r;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      sync_c2_r <= 1'b0;
    else
      sync_c2_r <= sync_c2_nxt;
  end

  wire logic synced_cmp2_output = cfg.sync_en ? sync_c2_r : c2_out;

  // ****************************************************************
  // gate source
  // ****************************************************************
  // gate source mux
  assign count_gate = cfg.gate_sel ? timer_gate_pin : synced_cmp2_output;

  // ****************************************************************
  // counter tick
  // ****************************************************************
  wire logic tick_nxt = rise_en & counter_on & (~gate_enable | count_gate);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      tick_r <= 1'b0;
    else
      tick_r <= tick_nxt;
  end
  assign counter_tick = tick_r;

  // ****************************************************************
  // mismatch latches
  // ****************************************************************
  logic [1:0] read_latch_r;
  logic [1:0] q1_latch_r;
  wire  logic [1:0] cmp_now = {c2_out, c1_out};
  wire  logic [1:0] cx_acc  = {acc & hit_c2, acc & hit_c1};

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++)
    begin : g_mm
      wire logic read_nxt = cx_acc[gi] ? cmp_now[gi] : read_latch_r[gi];

      always_ff @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
          q1_latch_r[gi] <= 1'b0;
        else
          q1_latch_r[gi] <= cmp_now[gi];
      end

      always_ff @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
          read_latch_r[gi] <= 1'b0;
        else
          read_latch_r[gi] <= read_nxt;
      end
    end
  endgenerate

  assign cmp_mismatch = read_latch_r ^ q1_latch_r;

  // ****************************************************************
  // read data
  // ****************************************************************
  logic [7:0] rd_byte;

  // ****************************************************************
  // read views
  // ****************************************************************
  // shared read
  wire logic [7:0] shared_rd = {c1_out, c2_out, 1'b0, shared_r};
  wire logic [7:0] c1_rd = {c1_ctrl_r[7], c1_out, c1_ctrl_r[5:0]};
  wire logic [7:0] c2_rd = {c2_ctrl_r[7], c2_out, c2_ctrl_r[5:0]};
  wire logic [7:0] port_rd = port_pins & ~analog_r;

  always_comb
  begin
    if (hit_c1)
      rd_byte = c1_rd;
    else if (hit_c2)
      rd_byte = c2_rd;
    else if (hit_sh)
      rd_byte = shared_rd;
    else if (hit_pt)
      rd_byte = port_rd;
    else if (hit_an)
      rd_byte = analog_r;
    else
      rd_byte = 8'h00;
  end

  // ****************************************************************
  // read data register
  // ****************************************************************
  wire logic        rd_setup   = psel & ~penable & ~pwrite;
  wire logic [31:0] prdata_nxt = rd_setup ? {24'h00_0000, rd_byte} : prdata;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata <= 32'h0000_0000;
    else
      prdata <= prdata_nxt;
  end

endmodule

/* sim/ctgs_asserts.sv */
// concurrent checks on the comparator gate block ports
`timescale 1ns/1ns
`include "ctgs_consts.svh"
module ctgs_asserts (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        cmp1_result,
  input wire logic        cmp2_result,
  input wire logic        timer_gate_pin,
  input wire logic        counter_on,
  input wire logic        gate_enable,
  input wire logic        counter_tick,
  input wire logic        count_gate,
  input wire logic        cmp1_hyst_en,
  input wire logic        cmp2_hyst_en
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic [4:0] sh_r;
  logic       pol1_r;
  logic       pol2_r;
  wire        wr    = psel && penable && pwrite;
  wire        rd_sh = psel && penable && !pwrite && paddr == `CTGS_OFF_SHARED_CTRL;
  wire  [7:0] exp_sh = {cmp1_result ^ pol1_r, cmp2_result ^ pol2_r, 1'b0, sh_r};
  // shadow of the written configuration
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      {sh_r, pol1_r, pol2_r} <= 7'h08;
    else if (wr && paddr == `CTGS_OFF_SHARED_CTRL)
      sh_r <= pwdata[4:0];
    else if (wr && paddr == `CTGS_OFF_CMP1_CTRL)
      pol1_r <= pwdata[4];
    else if (wr && paddr == `CTGS_OFF_CMP2_CTRL)
      pol2_r <= pwdata[4];
  a_gate_pin_sel: assert property (sh_r[1] |-> count_gate == timer_gate_pin)
    else $error("gate does not follow pin");
  a_async_pass: assert property (sh_r[1:0] == 2'b00 |-> count_gate == (cmp2_result ^ pol2_r))
    else $error("unsynced gate differs from comparator");
  a_sync_capture: assert property (sh_r[1:0] == 2'b01 && $past(sh_r[1:0]) == 2'b01 && $changed(count_gate)
    |-> count_gate == $past(cmp2_result ^ pol2_r)) else $error("synced gate not a registered capture");
  a_hyst_follow: assert property ({cmp1_hyst_en, cmp2_hyst_en} == sh_r[3:2])
    else $error("hysteresis enables differ from register");
  a_tick_single: assert property (counter_tick |=> !counter_tick)
    else $error("counter advanced on two edges in a row");
  a_tick_on: assert property (counter_tick |-> $past(counter_on))
    else $error("counter advanced while off");
  a_tick_gated: assert property (counter_tick |-> $past(!gate_enable || count_gate))
    else $error("counter advanced with gate closed");
  a_instr_rate: assert property (counter_tick && !sh_r[4] |=> (!counter_tick || sh_r[4]) [*3])
    else $error("instruction clock ticks too fast");
  a_mirror_read: assert property (rd_sh |-> prdata[7:0] == $past(exp_sh))
    else $error("shared register read wrong");
  c_sync_tick: cover property (counter_tick && sh_r[1:0] == 2'b01);
  c_instr_tick: cover property (counter_tick && !sh_r[4]);
  c_mirror: cover property (rd_sh);
endmodule

bind ctgs_top ctgs_asserts i_ctgs_asserts (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
  .cmp1_result, .cmp2_result, .timer_gate_pin, .counter_on, .gate_enable, .counter_tick, .count_gate,
  .cmp1_hyst_en, .cmp2_hyst_en);

/* sim/ctgs_timer_model.sv */
// gate counter on the far side of the block
`timescale 1ns/1ns
module ctgs_timer_model (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        run,
  input  wire logic        counter_tick,
  output logic             counter_on,
  output logic             gate_enable,
  output logic [15:0]      count
);
  assign counter_on  = run;
  assign gate_enable = 1'b1;
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      count <= 16'h0000;
    else if (counter_tick)
      count <= count + 16'h0001;
endmodule

/* sim/ctgs_tb_top.sv */
// self-checking bench for the comparator gate block
`timescale 1ns/1ns
`include "ctgs_consts.svh"
module ctgs_tb_top;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, e, run;
  logic        cmp1_result, cmp2_result, timer_gate_pin, counter_on, gate_enable, counter_tick, count_gate;
  logic        cmp1_hyst_en, cmp2_hyst_en;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic [7:0]  port_pins, w, a;
  logic [2:0]  prescale_sel;
  logic [1:0]  cmp_mismatch, cmp_enable;
  logic [15:0] count;
  int          error_cnt, n_tests, d, r;
  ctgs_top i_ctgs_top (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .cmp1_result, .cmp2_result, .timer_gate_pin, .port_pins, .prescale_sel, .counter_on, .gate_enable,
    .counter_tick, .count_gate, .cmp1_hyst_en, .cmp2_hyst_en, .cmp_mismatch, .cmp_enable);
  ctgs_timer_model i_ctgs_timer_model (.pclk, .presetn, .run, .counter_tick, .counter_on, .gate_enable, .count);
  initial
  begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic apb(input logic wr, input logic [11:0] ad, input logic [7:0] wd);
    @(posedge pclk);
    psel   <= 1'b1;
    pwrite <= wr;
    paddr  <= ad;
    pwdata <= {24'h00_0000, wd};
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
      @(posedge pclk);
    q = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic ticks(input int n);
    d = count;
    repeat (n) @(posedge pclk);
    d = count - d;
  endtask
  function automatic logic [31:0] exp_shared(input logic [7:0] v, input logic c1, input logic c2);
    return {24'h00_0000, c1, c2, 1'b0, v[4:0]};
  endfunction
  function automatic int exp_rate(input int alt, input int ps, input int n);
    return n / ((alt ? 2 : 8) << ps);
  endfunction
  task automatic final_report;
    $display("checks %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  initial
  begin
    {psel, penable, pwrite, paddr, pwdata, cmp1_result, cmp2_result} = '0;
    {timer_gate_pin, run, port_pins, prescale_sel} = '0;
    presetn = 1'b0;
    void'($urandom(32'h4b78_1c41));
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, `CTGS_OFF_SHARED_CTRL, 8'h00);
    check("shared reset", q, 32'h0000_0002);
    $display("reset test done");
    repeat (8)
    begin
      w = 8'($urandom);
      cmp1_result <= 1'($urandom);
      cmp2_result <= 1'($urandom);
      apb(1'b1, `CTGS_OFF_SHARED_CTRL, w);
      apb(1'b0, `CTGS_OFF_SHARED_CTRL, 8'h00);
      check("shared read", q, exp_shared(w, cmp1_result, cmp2_result));
      check("hysteresis", {cmp1_hyst_en, cmp2_hyst_en}, w[3:2]);
    end
    $display("shared register test done");
    cmp1_result <= 1'b0;
    apb(1'b0, `CTGS_OFF_CMP1_CTRL, 8'h00);
    cmp1_result <= 1'b1;
    repeat (8) @(posedge pclk);
    check("mismatch set", cmp_mismatch[0], 1'b1);
    apb(1'b0, `CTGS_OFF_SHARED_CTRL, 8'h00);
    repeat (2) @(posedge pclk);
    check("mismatch kept", cmp_mismatch[0], 1'b1);
    apb(1'b0, `CTGS_OFF_CMP1_CTRL, 8'h00);
    repeat (2) @(posedge pclk);
    check("mismatch cleared", cmp_mismatch[0], 1'b0);
    apb(1'b1, `CTGS_OFF_CMP1_CTRL, 8'hFF);
    apb(1'b0, `CTGS_OFF_CMP1_CTRL, 8'h00);
    check("cmp1 readback", q, {24'h00_0000, 1'b1, !cmp1_result, 6'h37});
    check("cmp1 enable", cmp_enable[0], 1'b1);
    apb(1'b1, `CTGS_OFF_CMP1_CTRL, 8'h00);
    a = 8'($urandom);
    port_pins <= 8'($urandom);
    apb(1'b1, `CTGS_OFF_ANALOG_SEL, a);
    apb(1'b0, `CTGS_OFF_PORT_READ, 8'h00);
    check("port read", q, {24'h00_0000, port_pins & ~a});
    apb(1'b0, 12'h020, 8'h00);
    check("unmapped error", e, 1'b1);
    check("unmapped data", q, 32'h0000_0000);
    $display("register side test done");
    run <= 1'b1;
    for (int i = 0; i < 6; i++)
    begin
      timer_gate_pin <= (i < 2) ? i[0] : !i[0];
      cmp2_result    <= (i < 2) ? !i[0] : i[0];
      apb(1'b1, `CTGS_OFF_SHARED_CTRL, i < 2 ? 8'h12 : (i < 4 ? 8'h10 : 8'h11));
      repeat (4) @(posedge pclk);
      ticks(20);
      check("gate", d != 0, i[0]);
    end
    $display("gate source test done");
    timer_gate_pin <= 1'b1;
    for (int i = 0; i < 6; i++)
    begin
      apb(1'b1, `CTGS_OFF_SHARED_CTRL, i[0] ? 8'h12 : 8'h02);
      prescale_sel <= 3'(i / 2);
      ticks(160);
      r = exp_rate(i[0], i / 2, 160);
      check("tick rate", d >= r - 2 && d <= r + 2, 1'b1);
    end
    $display("clock rate test done");
    final_report();
  end
  initial
  begin
    repeat (20000) @(posedge pclk);
    error_cnt++;
    final_report();
  end
endmodule
